// file: rtl/fsw_status_top.sv
// Status register and write-enable latch of a serial flash, reached over the serial link
`timescale 1ns/1ps
module fsw_status_top (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic sck_i,
  input wire logic cs_b_i,
  input wire logic si_i,
  input wire logic wp_b_i,
  input wire logic hold_rst_b_i,
  output logic so_o,
  output logic so_oe_o,
  output logic [7:0] status_o,
  output logic [3:0] block_protect_o,
  output logic quad_enable_o,
  output logic busy_o,
  output logic cmd_vld_o,
  output logic [7:0] cmd_op_o
);
  fsw_spi_if lnk ();

  logic [5:0] nv_ff;
  logic wel_ff;
  logic [7:0] opcode_ff;
  logic [7:0] data_ff;
  logic rst_en_ff;
  logic cmd_vld_ff;
  logic [7:0] cmd_op_ff;
  logic wp_s1_ff, wp_s2_ff, hold_s1_ff, hold_s2_ff;
  logic tmr_busy, tmr_susp, tmr_done, tmr_start;
  fsw_pkg::fsw_op_kind_t tmr_kind, op_kind;
  logic exec, allowed, writable, hw_reset, sw_reset;
  logic status_disable, quad_en, wp_low;
  logic [3:0] bp;
  logic [7:0] status;
  logic [7:0] rd_op;
  logic do_write_enable_cmd, do_write_disable_cmd, do_status_write_cmd, do_erase_all, do_write_op, do_volatile;
  logic do_suspend, do_resume;

  fsw_spi_front u_front (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .sck_i(sck_i),
    .cs_b_i(cs_b_i),
    .si_i(si_i),
    .lnk(lnk.front),
    .so_o(so_o),
    .so_oe_o(so_oe_o)
  );

  fsw_op_timer u_timer (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .start_i(tmr_start),
    .kind_i(op_kind),
    .suspend_i(do_suspend),
    .resume_i(do_resume),
    .abort_i(hw_reset || sw_reset),
    .busy_o(tmr_busy),
    .suspended_o(tmr_susp),
    .done_o(tmr_done),
    .kind_o(tmr_kind)
  );

  // Protect and hold/reset pin synchronisers
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      {wp_s1_ff, wp_s2_ff} <= 2'h3;
      {hold_s1_ff, hold_s2_ff} <= 2'h3;
    end else begin
      wp_s1_ff <= wp_b_i;
      wp_s2_ff <= wp_s1_ff;
      hold_s1_ff <= hold_rst_b_i;
      hold_s2_ff <= hold_s1_ff;
    end
  end

  // Status fields and pin roles
  assign status_disable = nv_ff[fsw_pkg::SR_STATUS_WRITE_DISABLE_BIT - fsw_pkg::SR_BP_LSB];
  assign quad_en = nv_ff[fsw_pkg::SR_QE_BIT - fsw_pkg::SR_BP_LSB];
  assign bp = nv_ff[fsw_pkg::SR_BP_MSB - fsw_pkg::SR_BP_LSB:0];
  assign wp_low = !quad_en && !wp_s2_ff;
  assign hw_reset = !quad_en && !hold_s2_ff;
  assign status = {nv_ff, wel_ff, tmr_busy};

  // Read data: the opcode byte selects which register streams out
  assign rd_op = (lnk.byte_idx == fsw_pkg::IDX_OPCODE) ? lnk.rx_byte : opcode_ff;
  always_comb begin
    lnk.tx_en = 1'b0;
    lnk.tx_byte = 8'h00;
    if (rd_op == fsw_pkg::OP_STATUS_READ) begin
      lnk.tx_en = 1'b1;
      lnk.tx_byte = status;
    end else if (rd_op == fsw_pkg::OP_FUNC_READ) begin
      lnk.tx_en = 1'b1;
      lnk.tx_byte = fsw_pkg::FUNC_REG_VALUE;
    end
  end

  // Opcode and first data byte capture
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      opcode_ff <= 8'h00;
      data_ff <= 8'h00;
    end else if (lnk.byte_vld) begin
      if (lnk.byte_idx == fsw_pkg::IDX_OPCODE) begin
        opcode_ff <= lnk.rx_byte;
      end else if (lnk.byte_idx == fsw_pkg::IDX_DATA) begin
        data_ff <= lnk.rx_byte;
      end
    end
  end

  // Command decode at the rising edge of chip select, on a byte boundary
  assign exec = lnk.frame_end && lnk.aligned && (lnk.byte_cnt != 2'h0) && !hw_reset;
  assign op_kind = fsw_pkg::op_class(opcode_ff);
  assign allowed = !tmr_busy || opcode_ff == fsw_pkg::OP_RESET_ENABLE ||
                   opcode_ff == fsw_pkg::OP_RESET || opcode_ff == fsw_pkg::OP_SUSPEND;
  assign writable = !(status_disable && wp_low);
  assign do_write_enable_cmd = exec && allowed && opcode_ff == fsw_pkg::OP_WRITE_ENABLE && lnk.byte_cnt == fsw_pkg::CNT_ONE;
  assign do_write_disable_cmd = exec && allowed && opcode_ff == fsw_pkg::OP_WRITE_DISABLE && lnk.byte_cnt == fsw_pkg::CNT_ONE;
  // A latch about to be consumed by an operation ending this cycle admits no further write
  assign do_status_write_cmd = exec && allowed && wel_ff && !tmr_done && !tmr_susp && writable &&
                   opcode_ff == fsw_pkg::OP_STATUS_WRITE &&
                   lnk.byte_cnt >= fsw_pkg::CNT_TWO;
  assign do_erase_all = (opcode_ff == fsw_pkg::OP_ARRAY_ERASE_A) || (opcode_ff == fsw_pkg::OP_ARRAY_ERASE_B);
  assign do_write_op = exec && allowed && wel_ff && !tmr_done && !tmr_susp && op_kind != fsw_pkg::OPK_NONE &&
                       opcode_ff != fsw_pkg::OP_STATUS_WRITE &&
                       !(do_erase_all && bp != fsw_pkg::BP_NONE);
  assign do_volatile = exec && allowed && (opcode_ff == fsw_pkg::OP_VOL_READ_PARAM_SET ||
                       opcode_ff == fsw_pkg::OP_VOL_BANK_WRITE);
  assign do_suspend = exec && tmr_busy && opcode_ff == fsw_pkg::OP_SUSPEND;
  assign do_resume = exec && allowed && tmr_susp && opcode_ff == fsw_pkg::OP_RESUME;
  assign sw_reset = exec && rst_en_ff && opcode_ff == fsw_pkg::OP_RESET;
  assign tmr_start = do_status_write_cmd || do_write_op;

  // Reset-enable arming: only the very next command may be the reset
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rst_en_ff <= 1'b0;
    end else if (exec) begin
      rst_en_ff <= (opcode_ff == fsw_pkg::OP_RESET_ENABLE);
    end
  end

  // Non-volatile status bits, written only by an accepted status write
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      nv_ff <= fsw_pkg::SR_NV_RESET;
    end else if (do_status_write_cmd) begin
      nv_ff <= data_ff[fsw_pkg::SR_STATUS_WRITE_DISABLE_BIT:fsw_pkg::SR_BP_LSB];
    end
  end

  // Write-enable latch; status write leaves it set until its own operation ends
  // A write enable landing in the cycle an operation ends follows that operation, so it wins
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      wel_ff <= 1'b0;
    end else if (hw_reset || sw_reset || do_write_disable_cmd) begin
      wel_ff <= 1'b0;
    end else if (do_write_enable_cmd) begin
      wel_ff <= 1'b1;
    end else if (tmr_done) begin
      wel_ff <= 1'b0;
    end
  end

  // Accepted-command report toward the array and parameter logic
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cmd_vld_ff <= 1'b0;
      cmd_op_ff <= 8'h00;
    end else begin
      cmd_vld_ff <= tmr_start || do_volatile || do_suspend || do_resume;
      if (tmr_start || do_volatile || do_suspend || do_resume) begin
        cmd_op_ff <= opcode_ff;
      end
    end
  end

  assign status_o = status;
  assign block_protect_o = bp;
  assign quad_enable_o = quad_en;
  assign busy_o = tmr_busy;
  assign cmd_vld_o = cmd_vld_ff;
  assign cmd_op_o = cmd_op_ff;

  // Latch behaviour and command gating checks
  a_write_enable_cmd_sets_wel:
  assert property (@(posedge clk_i) disable iff (!rst_b_i)
    exec && !tmr_busy && !hw_reset && opcode_ff == fsw_pkg::OP_WRITE_ENABLE && lnk.byte_cnt == fsw_pkg::CNT_ONE
    |=> wel_ff && status_o[fsw_pkg::SR_WEL_BIT])
  else $error("write enable did not set latch");

  a_write_disable_cmd_clears_wel:
  assert property (@(posedge clk_i) disable iff (!rst_b_i)
    exec && !tmr_busy && opcode_ff == fsw_pkg::OP_WRITE_DISABLE && lnk.byte_cnt == fsw_pkg::CNT_ONE |=> !wel_ff)
  else $error("write disable did not clear latch");

  a_done_clears_wel:
  assert property (@(posedge clk_i) disable iff (!rst_b_i)
    tmr_done && !do_write_enable_cmd |=> !wel_ff)
  else $error("latch not cleared after operation");

  a_status_write_cmd_keeps_wel:
  assert property (@(posedge clk_i) disable iff (!rst_b_i)
    do_status_write_cmd |=> wel_ff && tmr_busy)
  else $error("status write changed latch or no busy");

  a_busy_ignores_cmd:
  assert property (@(posedge clk_i) disable iff (!rst_b_i)
    exec && tmr_busy && opcode_ff == fsw_pkg::OP_WRITE_DISABLE |=> $stable(wel_ff))
  else $error("command accepted while busy");

  a_erase_protected:
  assert property (@(posedge clk_i) disable iff (!rst_b_i)
    exec && !tmr_busy && do_erase_all && bp != fsw_pkg::BP_NONE |=> !tmr_busy)
  else $error("array erase ran with protection set");

  a_no_wel_inhibit:
  assert property (@(posedge clk_i) disable iff (!rst_b_i)
    exec && !tmr_busy && !wel_ff && op_kind != fsw_pkg::OPK_NONE |=> !tmr_busy && $stable(nv_ff))
  else $error("write command ran without latch");

  a_status_write_cmd_locked:
  assert property (@(posedge clk_i) disable iff (!rst_b_i)
    exec && status_disable && !quad_en && !wp_s2_ff && opcode_ff == fsw_pkg::OP_STATUS_WRITE
    |=> $stable(nv_ff) ##1 $stable(nv_ff))
  else $error("locked status register was written");

  a_status_busy_bit:
  assert property (@(posedge clk_i) disable iff (!rst_b_i)
    tmr_start |=> status_o[fsw_pkg::SR_BUSY_BIT] [*3])
  else $error("busy bit not shown during operation");

  // Steps of the reset checks: the software reset firing command, then an idle timer and a cleared latch shared by both
  sequence s_sw_reset_fire;
    exec && rst_en_ff && opcode_ff == fsw_pkg::OP_RESET;
  endsequence

  sequence s_op_stopped;
    !tmr_busy && !tmr_susp && !wel_ff;
  endsequence

  a_sw_reset_stops:
  assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_sw_reset_fire |=> s_op_stopped)
  else $error("software reset left an operation running");

  a_hold_reset_stops:
  assert property (@(posedge clk_i) disable iff (!rst_b_i)
    hw_reset |=> s_op_stopped)
  else $error("hold pin reset left an operation running");

  a_suspend_idles:
  assert property (@(posedge clk_i) disable iff (!rst_b_i)
    do_suspend && tmr_kind != fsw_pkg::OPK_REG |=> tmr_susp && !tmr_busy)
  else $error("suspend did not pause the operation");

  a_volatile_no_wel:
  assert property (@(posedge clk_i) disable iff (!rst_b_i)
    exec && !tmr_busy && !wel_ff && opcode_ff == fsw_pkg::OP_VOL_READ_PARAM_SET
    |=> cmd_vld_o && cmd_op_o == fsw_pkg::OP_VOL_READ_PARAM_SET)
  else $error("volatile command refused without latch");

  // A write class command during an operation changes nothing and is not reported
  a_busy_blocks_write:
  assert property (@(posedge clk_i) disable iff (!rst_b_i)
    exec && tmr_busy && op_kind != fsw_pkg::OPK_NONE |=> $stable(nv_ff) && !cmd_vld_o)
  else $error("write command accepted while busy");

  a_status_written:
  assert property (@(posedge clk_i) disable iff (!rst_b_i)
    do_status_write_cmd
    |=> status_o[fsw_pkg::SR_STATUS_WRITE_DISABLE_BIT:fsw_pkg::SR_BP_LSB] == data_ff[fsw_pkg::SR_STATUS_WRITE_DISABLE_BIT:fsw_pkg::SR_BP_LSB])
  else $error("status write did not store its data");

endmodule

// file: rtl/fsw_pkg.sv
// Constants, opcodes and types shared by the status and write-enable logic
package fsw_pkg;

  // Status register layout
  localparam int SR_BUSY_BIT = 0;
  localparam int SR_WEL_BIT = 1;
  localparam int SR_BP_LSB = 2;
  localparam int SR_BP_MSB = 5;
  localparam int SR_QE_BIT = 6;
  localparam int SR_STATUS_WRITE_DISABLE_BIT = 7;
  localparam logic [5:0] SR_NV_RESET = 6'h00;
  localparam logic [3:0] BP_NONE = 4'h0;
  // Function register is out of scope here; its read answers this value
  localparam logic [7:0] FUNC_REG_VALUE = 8'h00;

  // Opcodes handled directly
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_FUNC_READ = 8'h48;
  localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7A;
  localparam logic [7:0] OP_ARRAY_ERASE_A = 8'hC7;
  localparam logic [7:0] OP_ARRAY_ERASE_B = 8'h60;
  localparam logic [7:0] OP_VOL_READ_PARAM_SET = 8'hC0;
  localparam logic [7:0] OP_VOL_BANK_WRITE = 8'h17;

  // Frame byte indices and counts, and last bit of a byte
  localparam logic [1:0] IDX_OPCODE = 2'h0;
  localparam logic [1:0] IDX_DATA = 2'h1;
  localparam logic [1:0] CNT_ONE = 2'h1;
  localparam logic [1:0] CNT_TWO = 2'h2;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // Internal operation times, least values rounded up to clock cycles
  localparam int CLK_PERIOD_NS = 10;
  localparam int PROG_TIME_NS = 1000;
  localparam int ERASE_TIME_NS = 20000;
  localparam int REG_TIME_NS = 500;
  localparam int TMR_W = 12;
  localparam logic [TMR_W-1:0] PROG_CYCLES = TMR_W'((PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] ERASE_CYCLES = TMR_W'((ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] REG_CYCLES = TMR_W'((REG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    OPK_NONE = 2'b00,
    OPK_PROG = 2'b01,
    OPK_ERASE = 2'b10,
    OPK_REG = 2'b11
  } fsw_op_kind_t;

  typedef enum logic [1:0] {
    TMR_IDLE = 2'b00,
    TMR_RUN = 2'b01,
    TMR_SUSP = 2'b10
  } fsw_tmr_state_t;

  // Class of a write-enable-gated opcode; OPK_NONE when no write-enable is needed
  function automatic fsw_op_kind_t op_class(input logic [7:0] op);
    fsw_op_kind_t k;
    k = OPK_NONE;
    case (op)
      8'h02, 8'h12, 8'h32, 8'h34, 8'h38, 8'h3E: k = OPK_PROG;
      8'hD7, 8'h20, 8'h21, 8'h52, 8'h5C, 8'hD8, 8'hDC, 8'hC7, 8'h60: k = OPK_ERASE;
      8'h01, 8'h42, 8'h65, 8'h63, 8'h85, 8'h83, 8'h15, 8'h18, 8'hC5, 8'h43, 8'h4A,
      8'h64, 8'h62, 8'hFB, 8'hE1, 8'hFD, 8'hE3, 8'hE4, 8'h2F, 8'hA6, 8'h91, 8'h7E,
      8'h98, 8'hE8: k = OPK_REG;
      default: k = OPK_NONE;
    endcase
    return k;
  endfunction

endpackage

// file: rtl/fsw_spi_if.sv
// Byte-level link between the serial front end and the status core
`timescale 1ns/1ps
interface fsw_spi_if;
  logic frame_start;
  logic frame_end;
  logic aligned;
  logic byte_vld;
  logic [7:0] rx_byte;
  logic [1:0] byte_idx;
  logic [1:0] byte_cnt;
  logic tx_en;
  logic [7:0] tx_byte;

  modport front (
    output frame_start, frame_end, aligned, byte_vld, rx_byte, byte_idx, byte_cnt,
    input tx_en, tx_byte
  );
  modport core (
    input frame_start, frame_end, aligned, byte_vld, rx_byte, byte_idx, byte_cnt,
    output tx_en, tx_byte
  );
endinterface

// file: rtl/fsw_spi_front.sv
// Serial front end: pin synchronisers, byte assembly and read-data shifter
`timescale 1ns/1ps
module fsw_spi_front (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic sck_i,
  input wire logic cs_b_i,
  input wire logic si_i,
  fsw_spi_if.front lnk,
  output logic so_o,
  output logic so_oe_o
);
  logic sck_s1_ff, sck_s2_ff, sck_d_ff;
  logic cs_s1_ff, cs_s2_ff, cs_d_ff;
  logic si_s1_ff, si_s2_ff;
  logic rise, fall, active;
  logic [2:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic [1:0] cnt_ff;
  logic vld_ff, start_ff, end_ff, aligned_ff;
  logic [7:0] rx_ff;
  logic [1:0] idx_ff;
  logic tx_act_ff;
  logic [7:0] tx_sh_ff;
  logic so_ff, so_oe_ff;

  // Two-stage synchronisers for every pin
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      {sck_s1_ff, sck_s2_ff, sck_d_ff} <= 3'h0;
      {cs_s1_ff, cs_s2_ff, cs_d_ff} <= 3'h7;
      {si_s1_ff, si_s2_ff} <= 2'h0;
    end else begin
      sck_s1_ff <= sck_i;
      sck_s2_ff <= sck_s1_ff;
      sck_d_ff <= sck_s2_ff;
      cs_s1_ff <= cs_b_i;
      cs_s2_ff <= cs_s1_ff;
      cs_d_ff <= cs_s2_ff;
      si_s1_ff <= si_i;
      si_s2_ff <= si_s1_ff;
    end
  end

  // Edge detection on synchronised levels
  assign active = !cs_s2_ff;
  assign rise = sck_s2_ff && !sck_d_ff && active;
  assign fall = !sck_s2_ff && sck_d_ff && active;

  // Bit and byte assembly, most significant bit first
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      bit_cnt_ff <= 3'h0;
      shift_ff <= 8'h00;
      cnt_ff <= 2'h0;
      vld_ff <= 1'b0;
      rx_ff <= 8'h00;
      idx_ff <= 2'h0;
    end else begin
      vld_ff <= 1'b0;
      if (cs_d_ff && !cs_s2_ff) begin
        bit_cnt_ff <= 3'h0;
        cnt_ff <= 2'h0;
      end else if (rise) begin
        shift_ff <= {shift_ff[6:0], si_s2_ff};
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
        if (bit_cnt_ff == fsw_pkg::BIT_LAST) begin
          vld_ff <= 1'b1;
          rx_ff <= {shift_ff[6:0], si_s2_ff};
          idx_ff <= cnt_ff;
          if (cnt_ff != 2'h3) begin
            cnt_ff <= cnt_ff + 2'h1;
          end
        end
      end
    end
  end

  // Frame boundary pulses
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      start_ff <= 1'b0;
      end_ff <= 1'b0;
      aligned_ff <= 1'b0;
    end else begin
      start_ff <= cs_d_ff && !cs_s2_ff;
      end_ff <= !cs_d_ff && cs_s2_ff;
      aligned_ff <= (bit_cnt_ff == 3'h0);
    end
  end

  // Read shifter: reloaded at every byte boundary so a register repeats
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      tx_act_ff <= 1'b0;
      tx_sh_ff <= 8'h00;
      so_ff <= 1'b0;
      so_oe_ff <= 1'b0;
    end else if (!active) begin
      tx_act_ff <= 1'b0;
      so_oe_ff <= 1'b0;
    end else if (vld_ff) begin
      tx_act_ff <= lnk.tx_en;
      tx_sh_ff <= lnk.tx_byte;
    end else if (fall && tx_act_ff) begin
      so_ff <= tx_sh_ff[7];
      so_oe_ff <= 1'b1;
      tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
    end
  end

  assign lnk.frame_start = start_ff;
  assign lnk.frame_end = end_ff;
  assign lnk.aligned = aligned_ff;
  assign lnk.byte_vld = vld_ff;
  assign lnk.rx_byte = rx_ff;
  assign lnk.byte_idx = idx_ff;
  assign lnk.byte_cnt = cnt_ff;
  assign so_o = so_ff;
  assign so_oe_o = so_oe_ff;

  a_repeat_byte:
  assert property (@(posedge clk_i) disable iff (!rst_b_i)
    vld_ff && lnk.tx_en && active |=> tx_sh_ff == $past(lnk.tx_byte) && tx_act_ff)
  else $error("read byte not reloaded at byte boundary");

endmodule

// file: rtl/fsw_op_timer.sv
// Internal operation timer with suspend, resume and abort
`timescale 1ns/1ps
module fsw_op_timer (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic start_i,
  input fsw_pkg::fsw_op_kind_t kind_i,
  input wire logic suspend_i,
  input wire logic resume_i,
  input wire logic abort_i,
  output logic busy_o,
  output logic suspended_o,
  output logic done_o,
  output fsw_pkg::fsw_op_kind_t kind_o
);
  fsw_pkg::fsw_tmr_state_t state_ff;
  fsw_pkg::fsw_op_kind_t kind_ff;
  logic [fsw_pkg::TMR_W-1:0] cnt_ff;
  logic done_ff;

  // Operation state and remaining cycles
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_ff <= fsw_pkg::TMR_IDLE;
      kind_ff <= fsw_pkg::OPK_NONE;
      cnt_ff <= '0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      case (state_ff)
        fsw_pkg::TMR_IDLE: begin
          if (start_i) begin
            state_ff <= fsw_pkg::TMR_RUN;
            kind_ff <= kind_i;
            case (kind_i)
              fsw_pkg::OPK_PROG: cnt_ff <= fsw_pkg::PROG_CYCLES;
              fsw_pkg::OPK_ERASE: cnt_ff <= fsw_pkg::ERASE_CYCLES;
              default: cnt_ff <= fsw_pkg::REG_CYCLES;
            endcase
          end
        end
        fsw_pkg::TMR_RUN: begin
          if (abort_i) begin
            state_ff <= fsw_pkg::TMR_IDLE;
          end else if (suspend_i && kind_ff != fsw_pkg::OPK_REG) begin
            state_ff <= fsw_pkg::TMR_SUSP;
          end else if (cnt_ff <= 1) begin
            state_ff <= fsw_pkg::TMR_IDLE;
            done_ff <= 1'b1;
          end else begin
            cnt_ff <= cnt_ff - 1'b1;
          end
        end
        fsw_pkg::TMR_SUSP: begin
          if (abort_i) begin
            state_ff <= fsw_pkg::TMR_IDLE;
          end else if (resume_i) begin
            state_ff <= fsw_pkg::TMR_RUN;
          end
        end
        default: state_ff <= fsw_pkg::TMR_IDLE;
      endcase
    end
  end

  assign busy_o = (state_ff == fsw_pkg::TMR_RUN);
  assign suspended_o = (state_ff == fsw_pkg::TMR_SUSP);
  assign done_o = done_ff;
  assign kind_o = kind_ff;

  a_done_ends_busy:
  assert property (@(posedge clk_i) disable iff (!rst_b_i)
    done_ff |-> !busy_o && $past(busy_o))
  else $error("busy still set after operation end");

  a_busy_bounded:
  assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(busy_o) && $past(state_ff) == fsw_pkg::TMR_IDLE |-> busy_o [*8])
  else $error("operation shorter than its time");

endmodule

// file: tb/fsw_host_model.sv
// Host serial controller model that frames bytes on the flash pins
`timescale 1ns/1ps
module fsw_host_model (
  input wire logic clk_i,
  input wire logic so_i,
  output logic sck_o,
  output logic cs_b_o,
  output logic si_o
);
  // Idle pins: clock low, chip select high
  initial begin
    sck_o = 1'b0;
    cs_b_o = 1'b1;
    si_o = 1'b0;
  end
  // One frame of n bytes, mode 0, MSB first; bytes 1 and 2 seen on the output pin are returned
  task automatic frame(input int n, input logic [15:0] tx, output logic [15:0] rx);
    logic [7:0] b;
    rx = 16'h0000;
    @(negedge clk_i);
    cs_b_o = 1'b0;
    for (int k = 0; k < n; k++) begin
      b = (k == 0) ? tx[15:8] : tx[7:0];
      for (int i = 7; i >= 0; i--) begin
        si_o = b[i];
        repeat (4) @(negedge clk_i);
        sck_o = 1'b1;
        if (k > 0 && k < 3) rx = {rx[14:0], so_i};
        repeat (4) @(negedge clk_i);
        sck_o = 1'b0;
      end
    end
    repeat (4) @(negedge clk_i);
    cs_b_o = 1'b1;
    si_o = ~si_o; // Released line shows the inverse, never the last bit
    repeat (12) @(negedge clk_i);
  endtask
endmodule

// file: tb/flash_status_write_enable_bench.sv
// Bench for the status register and write-enable latch block
`timescale 1ns/1ps
module flash_status_write_enable_bench;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic wp_b_i = 1'b1;
  logic hold_b = 1'b1;
  int oe_cnt = 0;
  logic sck, cs_b, si, so, so_oe, quad_enable, busy, cmd_vld;
  logic [7:0] status, cmd_op, last_op;
  logic [3:0] block_protect;
  logic [15:0] rx;
  int err_count = 0;
  int checks = 0;
  always #5 clk_i = ~clk_i;
  fsw_host_model i_host (.clk_i(clk_i), .so_i(so), .sck_o(sck), .cs_b_o(cs_b), .si_o(si));
  fsw_status_top i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .sck_i(sck), .cs_b_i(cs_b), .si_i(si),
    .wp_b_i(wp_b_i), .hold_rst_b_i(hold_b), .so_o(so), .so_oe_o(so_oe), .status_o(status),
    .block_protect_o(block_protect), .quad_enable_o(quad_enable), .busy_o(busy),
    .cmd_vld_o(cmd_vld), .cmd_op_o(cmd_op));
  // Keep the opcode of the last accepted command
  always @(posedge clk_i) if (cmd_vld === 1'b1) last_op <= cmd_op;
  // Count cycles in which the read output is driven
  always @(posedge clk_i) if (so_oe === 1'b1) oe_cnt <= oe_cnt + 1;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] op);
    i_host.frame(1, {op, 8'h00}, rx);
  endtask
  task automatic wr_status(input logic [7:0] d);
    i_host.frame(2, {8'h01, d}, rx);
  endtask
  // Status read twice in one frame must give the same byte both times
  // The output must have been driven during the frame and released after it
  task automatic rd_status(input logic [7:0] exp);
    int oe0;
    oe0 = oe_cnt;
    i_host.frame(3, 16'h0500, rx);
    chk(rx, {exp, exp});
    chk({so_oe, oe_cnt > oe0}, 2'b01);
  endtask
  // Latch clears one cycle after busy drops, so wait past it
  task automatic wait_idle;
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge clk_i);
    repeat (2) @(negedge clk_i);
    chk(busy, 1'b0);
  endtask
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Watchdog sized well past the expected run of about 5000 cycles
  initial begin
    #300us;
    err_count++;
    finish_test();
  end
  // Main sequence
  initial begin
    repeat (16) @(negedge clk_i);
    rst_b_i = 1'b1;
    repeat (4) @(negedge clk_i);
    chk(status, 8'h00);
    rd_status(8'h00);
    cmd(8'h02);
    chk({busy, status}, {1'b0, 8'h00});
    cmd(8'hC0);
    chk(last_op, 8'hC0);
    cmd(8'h17);
    chk({busy, last_op}, {1'b0, 8'h17});
    $display("Test gating done");
    cmd(8'h06);
    rd_status(8'h02);
    cmd(8'h04);
    chk(status, 8'h00);
    cmd(8'h06);
    wr_status(8'hFF);
    chk(status, 8'hFF);
    wait_idle();
    chk(status, 8'hFC);
    chk({block_protect, quad_enable}, {4'hF, 1'b1});
    cmd(8'h06);
    cmd(8'hC7);
    chk({busy, status}, {1'b0, 8'hFE});
    wr_status(8'h80);
    wait_idle();
    chk({quad_enable, status}, {1'b0, 8'h80});
    $display("Test status write done");
    wp_b_i = 1'b0;
    cmd(8'h06);
    wr_status(8'h00);
    wait_idle();
    chk(status, 8'h82);
    wp_b_i = 1'b1;
    wr_status(8'h00);
    wait_idle();
    chk(status, 8'h00);
    $display("Test write protect done");
    cmd(8'h06);
    cmd(8'h20);
    chk(busy, 1'b1);
    cmd(8'h04);
    cmd(8'h02);
    chk(last_op, 8'h20);
    rd_status(8'h03);
    i_host.frame(3, 16'h4800, rx);
    chk(rx, 16'h0000);
    cmd(8'h75);
    chk({busy, last_op}, {1'b0, 8'h75});
    cmd(8'h7A);
    chk(busy, 1'b1);
    wait_idle();
    chk(status, 8'h00);
    cmd(8'h06);
    cmd(8'h02);
    chk({busy, last_op}, {1'b1, 8'h02});
    wait_idle();
    cmd(8'h06);
    cmd(8'h98);
    chk({busy, last_op}, {1'b1, 8'h98});
    wait_idle();
    chk(status, 8'h00);
    $display("Test busy operations done");
    cmd(8'h06);
    cmd(8'hD8);
    cmd(8'h66);
    cmd(8'h99);
    chk({busy, status}, {1'b0, 8'h00});
    cmd(8'h06);
    cmd(8'h02);
    hold_b = 1'b0;
    repeat (4) @(negedge clk_i);
    chk({busy, status}, {1'b0, 8'h00});
    hold_b = 1'b1;
    repeat (4) @(negedge clk_i);
    $display("Test resets done");
    finish_test();
  end
endmodule
